// ==== rtl/scce_exec.v ====
`timescale 1ns/1ps
`include "scce_map.vh"

// Execute stage for call, clear, complement and watchdog kick
module scce_exec (
	input  wire                    core_clk_in,
	input  wire                    reset_in,
	input  wire                    instr_valid_in,
	input  wire [`SCCE_IW-1:0]     instr_in,
	input  wire [`SCCE_PCW-1:0]    pc_in,
	input  wire [`SCCE_DW-1:0]     upper_pc_latch_in,
	input  wire [`SCCE_DW-1:0]     file_data_in,
	output reg                     busy_out,
	output reg                     pc_load_out,
	output reg  [`SCCE_PCW-1:0]    pc_target_out,
	output reg                     stack_push_out,
	output reg  [`SCCE_PCW-1:0]    stack_top_out,
	output reg                     file_we_out,
	output reg  [`SCCE_FW-1:0]     file_addr_out,
	output reg  [`SCCE_DW-1:0]     file_wdata_out,
	output reg                     acc_we_out,
	output reg  [`SCCE_DW-1:0]     acc_wdata_out,
	output reg                     zero_flag_we_out,
	output reg                     zero_flag_out,
	output reg                     watchdog_counter_clr_out,
	output reg                     watchdog_prescaler_clr_out,
	output reg                     status_flags_set_out,
	output reg                     watchdog_expiry_flag_out,
	output reg                     power_down_flag_out
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_RUN   = 1'b0;
	localparam ST_FLUSH = 1'b1;

	wire [`SCCE_CLS_W-1:0] cls;
	wire [`SCCE_FW-1:0]    faddr;
	wire                   dest_file;
	wire [`SCCE_DW-1:0]    comp;
	reg                    state;
	reg                    next_state;
	reg                    take;
	wire [`SCCE_CLS_W-1:0] act_cls;
	wire [`SCCE_PCW-1:0]   call_target;
	wire [`SCCE_PCW-1:0]   return_addr;
	wire                   comp_zero;

	// ----------------------------------------
	// Next values of the output flops
	// ----------------------------------------
	reg                    next_pc_load;
	reg  [`SCCE_PCW-1:0]   next_pc_target;
	reg                    next_stack_push;
	reg  [`SCCE_PCW-1:0]   next_stack_top;
	reg                    next_file_we;
	reg  [`SCCE_FW-1:0]    next_file_addr;
	reg  [`SCCE_DW-1:0]    next_file_wdata;
	reg                    next_acc_we;
	reg  [`SCCE_DW-1:0]    next_acc_wdata;
	reg                    next_zero_flag_we;
	reg                    next_zero_flag;
	reg                    next_wdt_clr;
	reg                    next_prescaler_clr;
	reg                    next_flags_set;
	reg                    next_expiry_flag;
	reg                    next_power_down_flag;

	scce_decode u_decode (
		.instr_in  (instr_in),
		.class_out (cls)
	);

	// ----------------------------------------
	// Operand fields
	// ----------------------------------------
	// The outside reads the file combinationally from the address in the
	// word, so the complement is ready within the same cycle
	assign faddr       = instr_in[`SCCE_F_HI:`SCCE_F_LO];
	assign dest_file   = instr_in[`SCCE_D_BIT];
	assign comp        = ~file_data_in;
	assign comp_zero   = (comp == `SCCE_ZERO8);
	// Target page comes from the latch, not from the current counter
	assign call_target = {upper_pc_latch_in[`SCCE_LATCH_HI:`SCCE_LATCH_LO],
		instr_in[`SCCE_K_HI:`SCCE_K_LO]};
	// Wraps at the top of the space, as the counter itself does
	assign return_addr = pc_in + `SCCE_ONE13;
	// Only a word that is actually taken may act
	assign act_cls     = take ? cls : `SCCE_CLS_NONE;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// A call spends a second cycle flushing the prefetched word,
	// so any word offered then is dropped and busy tells the fetcher
	always @* begin
		take       = 1'b0;
		next_state = state;
		case (state)
			ST_RUN: begin
				take = instr_valid_in;
				if (instr_valid_in && cls == `SCCE_CLS_CALL) begin
					next_state = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always @(posedge core_clk_in) begin
		if (reset_in) begin
			state <= ST_RUN;
			busy_out <= 1'b0;
		end else begin
			state <= next_state;
			busy_out <= (next_state == ST_FLUSH);
		end
	end

	// ----------------------------------------
	// Program counter and return stack
	// ----------------------------------------
	// Only a call moves the counter; every other word leaves target and
	// return address as they were, so the outside may read them late
	always @* begin
		next_pc_load    = 1'b0;
		next_pc_target  = pc_target_out;
		next_stack_push = 1'b0;
		next_stack_top  = stack_top_out;
		case (act_cls)
			`SCCE_CLS_CALL: begin
				next_stack_push = 1'b1;
				next_stack_top  = return_addr;
				next_pc_load    = 1'b1;
				next_pc_target  = call_target;
			end
			default: begin
				next_pc_load    = 1'b0;
			end
		endcase
	end

	// Strobes last one cycle; target and return address hold
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			pc_load_out    <= 1'b0;
			pc_target_out  <= `SCCE_ZERO13;
			stack_push_out <= 1'b0;
			stack_top_out  <= `SCCE_ZERO13;
		end else begin
			pc_load_out    <= next_pc_load;
			pc_target_out  <= next_pc_target;
			stack_push_out <= next_stack_push;
			stack_top_out  <= next_stack_top;
		end
	end

	// ----------------------------------------
	// File register write port
	// ----------------------------------------
	// The address follows every file clear and complement, even when the
	// result goes to the accumulator; only the write strobe commits
	always @* begin
		next_file_we    = 1'b0;
		next_file_addr  = file_addr_out;
		next_file_wdata = file_wdata_out;
		case (act_cls)
			`SCCE_CLS_CLEAR_FILE_REG: begin
				next_file_we    = 1'b1;
				next_file_addr  = faddr;
				next_file_wdata = `SCCE_ZERO8;
			end
			`SCCE_CLS_COMPLEMENT_FILE_REG: begin
				next_file_addr  = faddr;
				if (dest_file) begin
					next_file_we    = 1'b1;
					next_file_wdata = comp;
				end
			end
			default: begin
				next_file_we    = 1'b0;
			end
		endcase
	end

	// Registered so the port never sees a decode glitch
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			file_we_out    <= 1'b0;
			file_addr_out  <= `SCCE_ZERO7;
			file_wdata_out <= `SCCE_ZERO8;
		end else begin
			file_we_out    <= next_file_we;
			file_addr_out  <= next_file_addr;
			file_wdata_out <= next_file_wdata;
		end
	end

	// ----------------------------------------
	// Accumulator write port
	// ----------------------------------------
	// A complement with destination bit clear lands here and leaves the
	// source register as it was
	always @* begin
		next_acc_we    = 1'b0;
		next_acc_wdata = acc_wdata_out;
		case (act_cls)
			`SCCE_CLS_CLEAR_ACCUMULATOR: begin
				next_acc_we    = 1'b1;
				next_acc_wdata = `SCCE_ZERO8;
			end
			`SCCE_CLS_COMPLEMENT_FILE_REG: begin
				if (!dest_file) begin
					next_acc_we    = 1'b1;
					next_acc_wdata = comp;
				end
			end
			default: begin
				next_acc_we    = 1'b0;
			end
		endcase
	end

	// Value holds after the strobe drops
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			acc_we_out    <= 1'b0;
			acc_wdata_out <= `SCCE_ZERO8;
		end else begin
			acc_we_out    <= next_acc_we;
			acc_wdata_out <= next_acc_wdata;
		end
	end

	// ----------------------------------------
	// Zero flag
	// ----------------------------------------
	// A call must leave every flag alone, so only the three data
	// instructions raise the write strobe
	always @* begin
		next_zero_flag_we = 1'b0;
		next_zero_flag    = zero_flag_out;
		case (act_cls)
			`SCCE_CLS_CLEAR_FILE_REG: begin
				next_zero_flag_we = 1'b1;
				next_zero_flag    = 1'b1;
			end
			`SCCE_CLS_CLEAR_ACCUMULATOR: begin
				next_zero_flag_we = 1'b1;
				next_zero_flag    = 1'b1;
			end
			`SCCE_CLS_COMPLEMENT_FILE_REG: begin
				next_zero_flag_we = 1'b1;
				next_zero_flag    = comp_zero;
			end
			`SCCE_CLS_CALL: begin
				next_zero_flag_we = 1'b0;
			end
			default: begin
				next_zero_flag_we = 1'b0;
			end
		endcase
	end

	// Flag value holds so the status register can take it late
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			zero_flag_we_out <= 1'b0;
			zero_flag_out    <= 1'b0;
		end else begin
			zero_flag_we_out <= next_zero_flag_we;
			zero_flag_out    <= next_zero_flag;
		end
	end

	// ----------------------------------------
	// Watchdog and status bits
	// ----------------------------------------
	// The held status bits only ever go to one here; clearing them is
	// left to reset and to instructions outside this block
	always @* begin
		next_wdt_clr         = 1'b0;
		next_prescaler_clr   = 1'b0;
		next_flags_set       = 1'b0;
		next_expiry_flag     = watchdog_expiry_flag_out;
		next_power_down_flag = power_down_flag_out;
		case (act_cls)
			`SCCE_CLS_KICK: begin
				next_wdt_clr         = 1'b1;
				next_prescaler_clr   = 1'b1;
				next_flags_set       = 1'b1;
				next_expiry_flag     = 1'b1;
				next_power_down_flag = 1'b1;
			end
			default: begin
				next_wdt_clr         = 1'b0;
			end
		endcase
	end

	// Clear pulses last one cycle; the two status bits are held
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			watchdog_counter_clr_out   <= 1'b0;
			watchdog_prescaler_clr_out <= 1'b0;
			status_flags_set_out       <= 1'b0;
			watchdog_expiry_flag_out   <= 1'b0;
			power_down_flag_out        <= 1'b0;
		end else begin
			watchdog_counter_clr_out   <= next_wdt_clr;
			watchdog_prescaler_clr_out <= next_prescaler_clr;
			status_flags_set_out       <= next_flags_set;
			watchdog_expiry_flag_out   <= next_expiry_flag;
			power_down_flag_out        <= next_power_down_flag;
		end
	end

endmodule

// ==== pkg/scce_map.vh ====
`ifndef SCCE_MAP_VH
`define SCCE_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SCCE_IW          14
`define SCCE_PCW         13
`define SCCE_FW          7
`define SCCE_DW          8

// ----------------------------------------
// Opcode patterns and masks
// ----------------------------------------
`define SCCE_CALL_MASK   14'h3800
`define SCCE_CALL_PAT    14'h2000
`define SCCE_CLEAR_FILE_REG_MASK   14'h3f80
`define SCCE_CLEAR_FILE_REG_PAT    14'h0180
`define SCCE_COMPLEMENT_FILE_REG_MASK   14'h3f00
`define SCCE_COMPLEMENT_FILE_REG_PAT    14'h0900
`define SCCE_CLEAR_ACCUMULATOR_CODE   14'h0103
`define SCCE_KICK_CODE   14'h0064

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCCE_K_HI        10
`define SCCE_K_LO        0
`define SCCE_F_HI        6
`define SCCE_F_LO        0
`define SCCE_D_BIT       7
`define SCCE_LATCH_HI    4
`define SCCE_LATCH_LO    3

// ----------------------------------------
// Values
// ----------------------------------------
`define SCCE_ZERO8       8'h00
`define SCCE_ZERO7       7'h00
`define SCCE_ZERO13      13'h0000
`define SCCE_ZERO14      14'h0000
`define SCCE_ONE13       13'h0001

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define SCCE_CLS_W       3
`define SCCE_CLS_NONE    3'h0
`define SCCE_CLS_CALL    3'h1
`define SCCE_CLS_CLEAR_FILE_REG    3'h2
`define SCCE_CLS_CLEAR_ACCUMULATOR    3'h3
`define SCCE_CLS_COMPLEMENT_FILE_REG    3'h4
`define SCCE_CLS_KICK    3'h5

`endif

// ==== rtl/scce_decode.v ====
`timescale 1ns/1ps
`include "scce_map.vh"

// Pure decoder: classifies one instruction word
module scce_decode (
	input  wire [`SCCE_IW-1:0]     instr_in,
	output reg  [`SCCE_CLS_W-1:0]  class_out
);

	// ----------------------------------------
	// Pattern match
	// ----------------------------------------
	function match;
		input [`SCCE_IW-1:0] word;
		input [`SCCE_IW-1:0] mask;
		input [`SCCE_IW-1:0] pat;
		begin
			match = ((word & mask) == pat);
		end
	endfunction

	// Fixed codes first; masks never overlap so order is only for clarity
	always @* begin
		class_out = `SCCE_CLS_NONE;
		if (instr_in == `SCCE_CLEAR_ACCUMULATOR_CODE) begin
			class_out = `SCCE_CLS_CLEAR_ACCUMULATOR;
		end else if (instr_in == `SCCE_KICK_CODE) begin
			class_out = `SCCE_CLS_KICK;
		end else if (match(instr_in, `SCCE_CALL_MASK, `SCCE_CALL_PAT)) begin
			class_out = `SCCE_CLS_CALL;
		end else if (match(instr_in, `SCCE_CLEAR_FILE_REG_MASK, `SCCE_CLEAR_FILE_REG_PAT)) begin
			class_out = `SCCE_CLS_CLEAR_FILE_REG;
		end else if (match(instr_in, `SCCE_COMPLEMENT_FILE_REG_MASK, `SCCE_COMPLEMENT_FILE_REG_PAT)) begin
			class_out = `SCCE_CLS_COMPLEMENT_FILE_REG;
		end
	end

endmodule

// ==== verif/scce_exec_sva.sv ====
`timescale 1ns/1ps
`include "scce_map.vh"
// Port-level checker for the execute stage
module scce_exec_sva (
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic        instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [12:0] pc_in,
	input wire logic [7:0]  upper_pc_latch_in,
	input wire logic [7:0]  file_data_in,
	input wire logic        busy_out,
	input wire logic        pc_load_out,
	input wire logic [12:0] pc_target_out,
	input wire logic        stack_push_out,
	input wire logic [12:0] stack_top_out,
	input wire logic        file_we_out,
	input wire logic [6:0]  file_addr_out,
	input wire logic [7:0]  file_wdata_out,
	input wire logic        acc_we_out,
	input wire logic [7:0]  acc_wdata_out,
	input wire logic        zero_flag_we_out,
	input wire logic        zero_flag_out,
	input wire logic        watchdog_counter_clr_out,
	input wire logic        watchdog_prescaler_clr_out,
	input wire logic        status_flags_set_out,
	input wire logic        watchdog_expiry_flag_out,
	input wire logic        power_down_flag_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Words the stage takes; a word offered while busy is dropped
	wire take = instr_valid_in && !busy_out;
	wire call = take && (instr_in[13:11] == 3'h4);
	wire clear_file_reg = take && (instr_in[13:7] == 7'h03);
	wire clear_accumulator = take && (instr_in == 14'h0103);
	wire complement_file_reg = take && (instr_in[13:8] == 6'h09);
	wire kick = take && (instr_in == 14'h0064);
	// Call: load cycle while busy, then free again
	sequence s_call; call; endsequence
	sequence s_second; pc_load_out && busy_out && !zero_flag_we_out ##1 !busy_out; endsequence
	a_call_push: assert property (
		s_call |=> stack_push_out && stack_top_out == $past(pc_in) + 13'h1)
		else $error("return address wrong");
	a_call_low: assert property (
		s_call |=> pc_target_out[10:0] == $past(instr_in[10:0]))
		else $error("target low bits wrong");
	a_call_high: assert property (
		s_call |=> pc_target_out[12:11] == $past(upper_pc_latch_in[4:3]))
		else $error("target high bits wrong");
	a_call_two: assert property (s_call |=> s_second)
		else $error("call timing wrong");
	a_busy_drop: assert property (
		busy_out |=> !pc_load_out && !file_we_out && !acc_we_out && !zero_flag_we_out)
		else $error("word taken while busy");
	a_clear_file_reg_zero: assert property (
		clear_file_reg |=> file_we_out && file_wdata_out == 8'h00 && zero_flag_out)
		else $error("clear file wrong");
	a_clear_file_reg_addr: assert property (clear_file_reg |=> file_addr_out == $past(instr_in[6:0]))
		else $error("file address wrong");
	a_clear_accumulator_zero: assert property (
		clear_accumulator |=> acc_we_out && acc_wdata_out == 8'h00 && zero_flag_out)
		else $error("clear accumulator wrong");
	a_complement_file_reg_flag: assert property (
		complement_file_reg |=> zero_flag_we_out && zero_flag_out == ($past(file_data_in) == 8'hff))
		else $error("complement zero flag wrong");
	a_complement_file_reg_dest: assert property (
		complement_file_reg |=> file_we_out == $past(instr_in[7]) && acc_we_out != file_we_out)
		else $error("complement destination wrong");
	a_kick_clear: assert property (
		kick |=> watchdog_counter_clr_out && watchdog_prescaler_clr_out)
		else $error("watchdog clear missing");
	a_kick_flags: assert property (
		kick |=> status_flags_set_out && watchdog_expiry_flag_out && power_down_flag_out)
		else $error("status bits not set");
endmodule

bind scce_exec scce_exec_sva u_sva (.*);

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "scce_map.vh"
// Self-checking bench for the execute stage
module tb;
	typedef struct packed {
		logic [13:0] ins;
		logic [7:0]  fd;
		logic [7:0]  stb;
		logic [7:0]  dat;
	} scce_row_t;
	logic        core_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        instr_valid_in = 1'b0;
	logic [13:0] instr_in = 14'h0000;
	logic [12:0] pc_in = 13'h0000;
	logic [7:0]  upper_pc_latch_in = 8'h00;
	logic [7:0]  file_data_in = 8'h00;
	logic        busy_out, pc_load_out, stack_push_out, file_we_out, acc_we_out;
	logic        zero_flag_we_out, zero_flag_out, status_flags_set_out;
	logic        watchdog_counter_clr_out, watchdog_prescaler_clr_out;
	logic        watchdog_expiry_flag_out, power_down_flag_out;
	logic [12:0] pc_target_out, stack_top_out;
	logic [6:0]  file_addr_out;
	logic [7:0]  file_wdata_out, acc_wdata_out;
	scce_row_t   rows [0:7];
	int          n_mismatch = 0;
	int          num_checks = 0;
	// All strobes side by side, pc load first
	wire  [7:0]  stb = {pc_load_out, stack_push_out, file_we_out, acc_we_out, zero_flag_we_out,
		watchdog_counter_clr_out, watchdog_prescaler_clr_out, status_flags_set_out};

	scce_exec uut (.*);

	always #50 core_clk_in = ~core_clk_in;

	// --------------------------------
	// Helpers
	// --------------------------------
	// Inputs change 1 ns after the edge so no race with the design
	task tick;
		@(posedge core_clk_in);
		#1;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Run is about 36 cycles; far beyond that means a hang
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop;
	end

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		// Word, file data, strobes, written value; last two never match
		rows[0] = '{14'h0185, 8'h5a, 8'h28, 8'h00};
		rows[1] = '{14'h01ff, 8'h33, 8'h28, 8'h00};
		rows[2] = '{14'h0103, 8'h77, 8'h18, 8'h00};
		rows[3] = '{14'h0910, 8'h13, 8'h18, 8'hec};
		rows[4] = '{14'h09ff, 8'hff, 8'h28, 8'h00};
		rows[5] = '{14'h0064, 8'h00, 8'h07, 8'h00};
		rows[6] = '{14'h0065, 8'h00, 8'h00, 8'h00};
		rows[7] = '{14'h0a00, 8'h00, 8'h00, 8'h00};
		repeat (20) tick;
		reset_in = 1'b0;
		instr_valid_in = 1'b1;
		// Back to back, one word per cycle
		for (int i = 0; i < 8; i++) begin
			instr_in = rows[i].ins;
			file_data_in = rows[i].fd;
			tick;
			chk(stb, rows[i].stb);
			if (rows[i].stb[5])
				chk({file_addr_out, file_wdata_out}, {rows[i].ins[6:0], rows[i].dat});
			if (rows[i].stb[4])
				chk(acc_wdata_out, rows[i].dat);
			if (rows[i].stb[3])
				chk(zero_flag_out, rows[i].dat == 8'h00);
		end
		chk({watchdog_expiry_flag_out, power_down_flag_out}, 2'h3);
		// Call at the top of the target range, then a word offered while busy
		instr_in = 14'h27ff;
		pc_in = 13'h0abc;
		upper_pc_latch_in = 8'h18;
		tick;
		chk({busy_out, stb}, 9'h1c0);
		chk({pc_target_out, stack_top_out}, {13'h1fff, 13'h0abd});
		instr_in = 14'h0103;
		tick;
		chk({busy_out, stb}, 9'h000);
		tick;
		chk(stb, 8'h18);
		// Only latch bits 4:3 reach the counter; return address wraps
		instr_in = 14'h2000;
		upper_pc_latch_in = 8'he7;
		pc_in = 13'h1fff;
		tick;
		chk({pc_target_out, stack_top_out}, 26'h0);
		instr_valid_in = 1'b0;
		tick;
		// Second reset in mid-run drops the held status bits
		reset_in = 1'b1;
		repeat (2) tick;
		chk({watchdog_expiry_flag_out, power_down_flag_out, busy_out, stb}, 11'h0);
		// A word offered at the very first edge after release is taken
		reset_in = 1'b0;
		instr_valid_in = 1'b1;
		instr_in = 14'h0064;
		tick;
		chk({watchdog_expiry_flag_out, power_down_flag_out, stb}, 10'h307);
		report_and_stop;
	end
endmodule
